// file: core/pds_consts.vh
// Constants for the PWM dither sequencer
`ifndef PDS_CONSTS_VH
`define PDS_CONSTS_VH
`define PDS_CLK_MHZ 100
`define PDS_UPDATE_US 16
`define PDS_TMR_CLK_MHZ 16
`define PDS_PERIOD_TICKS 256
`define PDS_TICK_DIV ((`PDS_CLK_MHZ + `PDS_TMR_CLK_MHZ - 1) / `PDS_TMR_CLK_MHZ)
`define PDS_STATES 16
`define PDS_XFER_CYCLES 8
`define PDS_XFER_WINDOW 512
`define PDS_SYS_CLK_MHZ 32
`define PDS_ADC_BITS 10
`define PDS_ADC_RATE_MHZ_X10K 16384
`define PDS_ADC_PERIOD_CYC 61035
`define PDS_SUM_COUNT 16
`define PDS_BAUD 115200
`define PDS_BIT_CYC ((`PDS_CLK_MHZ * 1000000) / `PDS_BAUD)
`define PDS_TARGET_MAX 12'hFF0
`define PDS_RST_BASE 8'h00
`define PDS_RST_FACTOR 4'h0
`endif

// file: core/pds_pattern_rom.v
// Adder pattern table, one 16-bit column per dither factor, registered read
`timescale 1ns/10ps
`default_nettype none
module pds_pattern_rom (
	input wire clock_i, // System clock
	input wire ce_i, // Clock enable
	input wire [3:0] factor_i, // Dither factor column
	input wire [3:0] state_i, // State row, 0 means state 1
	output reg bit_o // Registered adder bit
);
	// ************************************************************
	// Table lookup
	// ************************************************************
	reg [15:0] col; // Bit k is state k+1
	// Columns written bit 15 = state 16 down to bit 0 = state 1
	always @* begin
		case (factor_i)
			4'h0: col = 16'h0000;
			4'h1: col = 16'h0001;
			4'h2: col = 16'h0101;
			4'h3: col = 16'h0421;
			4'h4: col = 16'h1111;
			4'h5: col = 16'h1249;
			4'h6: col = 16'h2525;
			4'h7: col = 16'h2A55;
			4'h8: col = 16'h5555;
			4'h9: col = 16'hD5AA;
			4'hA: col = 16'hDADA;
			4'hB: col = 16'hEDB6;
			4'hC: col = 16'hEEEE;
			4'hD: col = 16'hFBDE;
			4'hE: col = 16'hFEFE;
			4'hF: col = 16'hFFFE;
			default: col = 16'h0000;
		endcase
	end
	// Registered read keeps the duty path short
	always @(posedge clock_i) begin
		if (ce_i) begin
			bit_o <= col[state_i];
		end
	end
endmodule
`default_nettype wire

// file: core/pds_monitor.v
// Monitor path: conversion timer, 16-sample sum, serial readout
`timescale 1ns/10ps
`default_nettype none
`include "pds_consts.vh"
module pds_monitor #(
	parameter ADC_PERIOD = `PDS_ADC_PERIOD_CYC, // Cycles per conversion start
	parameter BIT_CYC = `PDS_BIT_CYC // Cycles per serial bit
) (
	input wire clock_i, // System clock
	input wire rst_i, // Sync reset, active high
	input wire ce_i, // Clock enable
	input wire adc_done_i, // Conversion complete strobe
	input wire [9:0] adc_data_i, // Conversion result
	output reg adc_start_o, // Conversion start pulse
	output reg [13:0] sum_o, // Sum of 16 results
	output reg sum_valid_o, // New sum pulse
	output reg tx_o // Serial monitor line
);
	reg [31:0] tmr_q; // Interval timer
	reg [3:0] cnt_q; // Results in current sum
	reg [13:0] acc_q; // Running sum
	reg [9:0] shf_q; // Serial frame shifter
	reg [3:0] bits_q; // Bits left in frame
	reg [15:0] bcnt_q; // Bit timer
	reg [1:0] nib_q; // Hex digits left
	reg [13:0] tx_val_q; // Value being printed
	// ************************************************************
	// Hardware conversion trigger
	// ************************************************************
	always @(posedge clock_i) begin
		if (rst_i) begin
			tmr_q <= 32'h0;
			adc_start_o <= 1'b0;
		end else if (ce_i) begin
			adc_start_o <= 1'b0;
			if (tmr_q >= ADC_PERIOD - 1) begin
				tmr_q <= 32'h0;
				adc_start_o <= 1'b1;
			end else begin
				tmr_q <= tmr_q + 32'h1;
			end
		end
	end
	// ************************************************************
	// Sum of 16 consecutive results
	// ************************************************************
	always @(posedge clock_i) begin
		if (rst_i) begin
			cnt_q <= 4'h0;
			acc_q <= 14'h0;
			sum_o <= 14'h0;
			sum_valid_o <= 1'b0;
		end else if (ce_i) begin
			sum_valid_o <= 1'b0;
			if (adc_done_i) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q == 4'hF) begin
					sum_o <= acc_q + {4'h0, adc_data_i};
					sum_valid_o <= 1'b1;
					acc_q <= 14'h0;
				end else begin
					acc_q <= acc_q + {4'h0, adc_data_i};
				end
			end
		end
	end
	// ************************************************************
	// Serial readout: four hex digits of each sum that arrives between strings, 8N1
	// ************************************************************
	function [7:0] hex;
		input [3:0] v;
		hex = v < 4'hA ? {4'h3, v} : 8'h37 + {4'h0, v};
	endfunction
	always @(posedge clock_i) begin
		if (rst_i) begin
			shf_q <= 10'h3FF;
			bits_q <= 4'h0;
			bcnt_q <= 16'h0;
			nib_q <= 2'h0;
			tx_val_q <= 14'h0;
			tx_o <= 1'b1;
		end else if (ce_i) begin
			if (bits_q != 4'h0) begin
				if (bcnt_q >= BIT_CYC - 1) begin
					bcnt_q <= 16'h0;
					tx_o <= shf_q[0];
					shf_q <= {1'b1, shf_q[9:1]};
					bits_q <= bits_q - 4'h1;
				end else begin
					bcnt_q <= bcnt_q + 16'h1;
				end
			end else if (nib_q != 2'h0 || sum_valid_o) begin
				// Skip a sum that lands mid-string; readings are live only
				if (sum_valid_o && nib_q == 2'h0) begin
					tx_val_q <= sum_o;
					nib_q <= 2'h3;
					shf_q <= {1'b1, hex({2'b00, sum_o[13:12]}), 1'b0};
				end else begin
					nib_q <= nib_q - 2'h1;
					shf_q <= {1'b1, hex(nib_q == 2'h3 ? tx_val_q[11:8] :
						nib_q == 2'h2 ? tx_val_q[7:4] : tx_val_q[3:0]), 1'b0};
				end
				bits_q <= 4'hA;
				bcnt_q <= 16'h0;
			end
		end
	end
endmodule
`default_nettype wire

// file: core/pds_top.v
// PWM dither sequencer: carrier, auto transfer, duty channel, closed loop
// ************************************************************
// ************************************************************
`timescale 1ns/10ps
`default_nettype none
`include "pds_consts.vh"
module pds_top #(
	parameter TICK_DIV = `PDS_TICK_DIV, // System clocks per timer tick
	parameter PERIOD_TICKS = `PDS_PERIOD_TICKS, // Ticks per update interval
	parameter ADC_PERIOD = `PDS_ADC_PERIOD_CYC, // Cycles per conversion
	parameter BIT_CYC = `PDS_BIT_CYC, // Cycles per serial bit
	parameter LOOP_BLOCKS = 16 // Sums per correction step (16 x 16 = 256)
) (
	input wire clock_i, // System clock
	input wire rst_i, // Sync reset, active high
	input wire ce_i, // Clock enable, freezes all state
	input wire [11:0] target_i, // Target: base in [11:4], factor in [3:0]
	input wire closed_loop_i, // Enable ADC correction
	input wire adc_done_i, // Conversion complete strobe
	input wire [9:0] adc_data_i, // Conversion result
	output reg pwm_o, // Dithered PWM to RC filter
	output reg reload_o, // Sequence reload pulse
	output reg xfer_busy_o, // Auto transfer in progress
	output reg [7:0] duty_o, // Compare setting in use
	output reg [3:0] factor_o, // Dither factor in use
	output reg adc_start_o, // Conversion start pulse
	output reg [13:0] sum_o, // Last 16-sample sum
	output reg sum_valid_o, // New sum pulse
	output reg tx_o // Serial monitor line
);
	// ************************************************************
	// Carrier channel timebase
	// ************************************************************
	reg [7:0] div_q; // Prescaler to timer ticks
	reg [8:0] tick_q; // Tick in period
	reg expire_q; // Carrier expiry pulse
	wire tick = (div_q == TICK_DIV - 1); // One timer tick
	always @(posedge clock_i) begin
		if (rst_i) begin
			div_q <= 8'h00;
			tick_q <= 9'h000;
			expire_q <= 1'b0;
		end else if (ce_i) begin
			expire_q <= 1'b0;
			div_q <= tick ? 8'h00 : div_q + 8'h01;
			if (tick) begin
				if (tick_q == PERIOD_TICKS - 1) begin
					tick_q <= 9'h000;
					expire_q <= 1'b1;
				end else begin
					tick_q <= tick_q + 9'h001;
				end
			end
		end
	end
	// ************************************************************
	// Auto transfer unit
	// ************************************************************
	localparam XS_IDLE = 2'b00; // Wait for expiry
	localparam XS_READ = 2'b01; // Table read in flight
	localparam XS_WAIT = 2'b10; // Pad out transfer time
	reg [1:0] xs_q; // Transfer state
	reg [3:0] xcnt_q; // Transfer cycle counter
	reg [3:0] state_q; // Pattern state 0..15
	reg [7:0] base_q; // Base captured at re-arm
	reg [3:0] fac_q; // Factor captured at re-arm
	reg [3:0] adj_q; // Closed-loop factor
	reg [7:0] next_q; // Staged compare value
	wire pat_bit; // Adder bit from table
	wire [11:0] tgt = target_i > `PDS_TARGET_MAX ? `PDS_TARGET_MAX : target_i;
	pds_pattern_rom u_rom (
		.clock_i(clock_i),
		.ce_i(ce_i),
		.factor_i(fac_q),
		.state_i(state_q),
		.bit_o(pat_bit)
	);
	always @(posedge clock_i) begin
		if (rst_i) begin
			xs_q <= XS_IDLE;
			xcnt_q <= 4'h0;
			state_q <= 4'h0;
			base_q <= `PDS_RST_BASE;
			fac_q <= `PDS_RST_FACTOR;
			next_q <= 8'h00;
			reload_o <= 1'b0;
			xfer_busy_o <= 1'b0;
			factor_o <= `PDS_RST_FACTOR;
		end else if (ce_i) begin
			reload_o <= 1'b0;
			case (xs_q)
				XS_IDLE: begin
					if (expire_q) begin
						xs_q <= XS_READ;
						xcnt_q <= 4'h0;
						xfer_busy_o <= 1'b1;
					end
				end
				XS_READ: begin
					xcnt_q <= xcnt_q + 4'h1;
					if (xcnt_q == 4'h1) begin
						// Factor 0 never adds, so base 0xFF cannot wrap in open loop; in closed loop adj_q is used at any base and can wrap past 0xFF
						next_q <= base_q + {7'h00, pat_bit};
						xs_q <= XS_WAIT;
					end
				end
				XS_WAIT: begin
					xcnt_q <= xcnt_q + 4'h1;
					if (xcnt_q == `PDS_XFER_CYCLES - 1) begin
						xs_q <= XS_IDLE;
						xfer_busy_o <= 1'b0;
						state_q <= state_q + 4'h1;
						if (state_q == 4'hF) begin
							reload_o <= 1'b1;
							base_q <= tgt[11:4];
							fac_q <= closed_loop_i ? adj_q : tgt[3:0];
							factor_o <= closed_loop_i ? adj_q : tgt[3:0];
						end
					end
				end
				default: xs_q <= XS_IDLE;
			endcase
		end
	end
	// ************************************************************
	// Duty channel: compare updates at period start only
	// ************************************************************
	always @(posedge clock_i) begin
		if (rst_i) begin
			duty_o <= 8'h00;
			pwm_o <= 1'b0;
		end else if (ce_i) begin
			// New value waits for the next period to avoid a glitch pulse
			if (tick && tick_q == PERIOD_TICKS - 1) begin
				duty_o <= next_q;
			end
			pwm_o <= (tick_q[7:0] < duty_o);
		end
	end
	// ************************************************************
	// Monitor path and closed-loop correction
	// ************************************************************
	wire mon_start; // From monitor
	wire [13:0] mon_sum; // From monitor
	wire mon_valid; // From monitor
	wire mon_tx; // From monitor
	pds_monitor #(
		.ADC_PERIOD(ADC_PERIOD),
		.BIT_CYC(BIT_CYC)
	) u_mon (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.adc_done_i(adc_done_i),
		.adc_data_i(adc_data_i),
		.adc_start_o(mon_start),
		.sum_o(mon_sum),
		.sum_valid_o(mon_valid),
		.tx_o(mon_tx)
	);
	reg [4:0] blk_q; // Sums in current block
	reg [17:0] bacc_q; // Block accumulator
	wire [17:0] bsum = bacc_q + {4'h0, mon_sum}; // Block total incl. newest
	wire [11:0] meas = bsum[17:6]; // 256 x 10 bits scaled to 12
	always @(posedge clock_i) begin
		if (rst_i) begin
			blk_q <= 5'h00;
			bacc_q <= 18'h0;
			adj_q <= `PDS_RST_FACTOR;
			adc_start_o <= 1'b0;
			sum_o <= 14'h0;
			sum_valid_o <= 1'b0;
			tx_o <= 1'b1;
		end else if (ce_i) begin
			adc_start_o <= mon_start;
			sum_o <= mon_sum;
			sum_valid_o <= mon_valid;
			tx_o <= mon_tx;
			if (!closed_loop_i) begin
				adj_q <= tgt[3:0];
				blk_q <= 5'h00;
				bacc_q <= 18'h0;
			end else if (mon_valid) begin
				if (blk_q == LOOP_BLOCKS - 1) begin
					blk_q <= 5'h00;
					bacc_q <= 18'h0;
					// Bang-bang step; factor saturates inside the base code
					if (meas < tgt && adj_q != 4'hF) begin
						adj_q <= adj_q + 4'h1;
					end else if (meas > tgt && adj_q != 4'h0) begin
						adj_q <= adj_q - 4'h1;
					end
				end else begin
					blk_q <= blk_q + 5'h01;
					bacc_q <= bsum;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: bench/pds_adc_model.sv
// Converter model behind the RC filter
`timescale 1ns/10ps
`default_nettype none
module pds_adc_model (
	input wire logic clock_i, // Clock
	input wire logic start_i, // Start pulse
	input wire logic [9:0] level_i, // Filtered level
	input wire logic [3:0] delay_i, // Cycles to convert, 1 or more
	output var logic done_o, // Done pulse
	output var logic [9:0] data_o // Result
);
	logic [3:0] cnt_q = 4'h0; // Cycles left, 0 when idle
	initial done_o = 1'b0;
	initial data_o = 10'h000;
	// Data toggles between results so a read one cycle late never looks valid
	always @(posedge clock_i) begin
		done_o <= 1'b0;
		data_o <= ~data_o;
		if (start_i) begin
			cnt_q <= delay_i;
		end else if (cnt_q == 4'h1) begin
			done_o <= 1'b1;
			data_o <= level_i;
			cnt_q <= 4'h0;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule
`default_nettype wire

// file: bench/pds_properties.sv
// Port checker for the PWM dither sequencer
`timescale 1ns/10ps
`default_nettype none
module pds_checker #(
	parameter TICK_DIV = 7, // Clocks per tick
	parameter PERIOD_TICKS = 256, // Ticks per update
	parameter ADC_PERIOD = 50 // Clocks per conversion
) (
	input wire logic clock_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic pwm_o, // PWM
	input wire logic reload_o, // Reload pulse
	input wire logic xfer_busy_o, // Busy
	input wire logic [7:0] duty_o, // Compare value
	input wire logic [3:0] factor_o, // Factor
	input wire logic adc_start_o, // Start
	input wire logic sum_valid_o, // Sum strobe
	input wire logic tx_o // Serial
);
	reg [15:0] gap_q, agap_q, run_q; // Distances and high run
	reg seen_q, aseen_q; // First event passed
	// The first gap after reset is not judged
	always @(posedge clock_i) begin
		gap_q <= reload_o ? 16'h0000 : gap_q + 16'h0001;
		agap_q <= adc_start_o ? 16'h0000 : agap_q + 16'h0001;
		run_q <= pwm_o ? run_q + 16'h0001 : 16'h0000;
		seen_q <= !rst_i && (seen_q || reload_o);
		aseen_q <= !rst_i && (aseen_q || adc_start_o);
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	a_reset_idle: assert property ($past(rst_i) |-> !pwm_o && !reload_o && tx_o && duty_o == 8'h00)
		else $error("outputs busy after reset");
	a_reload_spacing: assert property (reload_o && seen_q |-> gap_q == 16 * PERIOD_TICKS * TICK_DIV - 1)
		else $error("reload spacing wrong");
	a_busy_len: assert property ($rose(xfer_busy_o) |-> xfer_busy_o [*8] ##1 !xfer_busy_o)
		else $error("transfer length wrong");
	a_reload_after_xfer: assert property ($rose(reload_o) |-> !xfer_busy_o && $past(xfer_busy_o))
		else $error("reload not after transfer");
	a_duty_steady: assert property ($changed(duty_o) |=> $stable(duty_o) [*8])
		else $error("duty changed twice");
	a_pwm_high: assert property ($fell(pwm_o) |-> run_q == duty_o * TICK_DIV || run_q == $past(duty_o) * TICK_DIV)
		else $error("pwm high time wrong");
	a_start_gap: assert property (adc_start_o && aseen_q |-> agap_q == ADC_PERIOD - 1)
		else $error("conversion spacing wrong");
	a_sum_pulse: assert property (sum_valid_o |=> !sum_valid_o)
		else $error("sum strobe too long");
	a_factor_rearm: assert property ($changed(factor_o) |-> reload_o || $past(reload_o))
		else $error("factor changed off reload");
endmodule
bind pds_top pds_checker #(.TICK_DIV(TICK_DIV), .PERIOD_TICKS(PERIOD_TICKS), .ADC_PERIOD(ADC_PERIOD)) pds_checker_inst (
	.clock_i(clock_i), .rst_i(rst_i), .pwm_o(pwm_o), .reload_o(reload_o), .xfer_busy_o(xfer_busy_o),
	.duty_o(duty_o), .factor_o(factor_o), .adc_start_o(adc_start_o), .sum_valid_o(sum_valid_o), .tx_o(tx_o));
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the PWM dither sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int TD = 1; // One-clock tick keeps the run short
	localparam int PER = 256 * TD; // Clocks per update
	// Adder columns per factor, bit 0 is state 1
	localparam logic [15:0] COL [16] = '{16'h0000, 16'h0001, 16'h0101, 16'h0421, 16'h1111, 16'h1249, 16'h2525,
		16'h2A55, 16'h5555, 16'hD5AA, 16'hDADA, 16'hEDB6, 16'hEEEE, 16'hFBDE, 16'hFEFE, 16'hFFFE};
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic loop_en = 1'b0; // Closed loop
	logic [11:0] target = 12'h000;
	logic [9:0] level = 10'h000; // Level at the converter
	logic [3:0] delay = 4'h3; // Conversion time
	wire done, pwm, reload, busy, start, sv, tx;
	wire [9:0] data;
	wire [7:0] duty;
	wire [3:0] factor;
	wire [13:0] sum;
	int err_count = 0;
	int n_compared = 0;
	int seed = 2158;
	always #5 clock_i = ~clock_i;
	pds_top #(.TICK_DIV(TD), .ADC_PERIOD(50), .BIT_CYC(4), .LOOP_BLOCKS(2)) pds_top_inst (.clock_i(clock_i),
		.rst_i(rst_i), .ce_i(1'b1), .target_i(target), .closed_loop_i(loop_en), .adc_done_i(done),
		.adc_data_i(data), .pwm_o(pwm), .reload_o(reload), .xfer_busy_o(busy), .duty_o(duty), .factor_o(factor),
		.adc_start_o(start), .sum_o(sum), .sum_valid_o(sv), .tx_o(tx));
	pds_adc_model pds_adc_model_inst (.clock_i(clock_i), .start_i(start), .level_i(level), .delay_i(delay),
		.done_o(done), .data_o(data));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic wait_reload();
		int n;
		for (n = 0; n < 17 * PER && reload !== 1'b1; n++) @(negedge clock_i);
		chk("reload", 16'h0001, 16'(reload === 1'b1));
		@(negedge clock_i);
	endtask
	task automatic wait_sum();
		int n;
		for (n = 0; n < 2000 && sv !== 1'b1; n++) @(negedge clock_i);
		chk("sum strobe", 16'h0001, 16'(sv === 1'b1));
		@(negedge clock_i);
	endtask
	// Samples the 16 periods of one whole sequence, state 1 first
	task automatic run_target(input logic [11:0] t);
		logic [11:0] c;
		logic [7:0] seq [16];
		int k, ok, highs;
		c = (t > 12'hFF0) ? 12'hFF0 : t;
		target = t;
		wait_reload();
		// New sequence reaches the compare two periods after the reload
		repeat (PER * 5 / 2) @(negedge clock_i);
		highs = 0;
		for (k = 0; k < 16; k++) begin
			seq[k] = duty;
			repeat (PER) begin
				@(negedge clock_i);
				highs += (k == 0 && pwm === 1'b1);
			end
		end
		ok = 1;
		for (k = 0; k < 16; k++) begin
			if (seq[k] !== c[11:4] + 8'(COL[c[3:0]][k])) ok = 0;
		end
		chk("duty sequence", 16'h0001, 16'(ok));
		if (c[3:0] == 4'h0) chk("pwm high clocks", 16'(c[11:4] * TD), 16'(highs));
		$display("target %h done", t);
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Hang guard, well past the planned run
	initial begin
		#900000;
		err_count++;
		$display("[FAIL] run expected done seen timeout");
		close_out();
	end
	initial begin
		int k;
		logic [7:0] ch;
		repeat (16) @(negedge clock_i);
		rst_i = 1'b0;
		chk("reset outputs", 16'h0001, {duty, factor, pwm, reload, busy, tx});
		run_target(12'h807);
		run_target(12'h400);
		run_target(12'hA7F);
		run_target(12'hFFF);
		repeat (2) run_target(12'($random(seed)));
		delay = 4'(1 + ($random(seed) & 7));
		level = 10'($random(seed));
		wait_sum();
		wait_sum();
		chk("sample sum", {2'b00, level, 4'h0}, 16'(sum));
		for (k = 0; k < 40 && tx !== 1'b0; k++) @(negedge clock_i);
		ch = 8'h00;
		for (k = 0; k < 8; k++) begin
			repeat (4) @(negedge clock_i);
			ch = {tx, ch[7:1]};
		end
		repeat (4) @(negedge clock_i);
		// First digit of the sum is its top two bits, then the stop bit
		chk("serial char", {7'h00, 1'b1, 8'h30 | {6'h00, level[9:8]}}, {7'h00, tx, ch});
		$display("monitor test done");
		loop_en = 1'b1;
		level = 10'h000;
		target = 12'h808;
		repeat (5) wait_reload();
		chk("loop factor", 16'h0001, 16'(factor > 4'h8));
		$display("closed loop test done");
		close_out();
	end
endmodule
`default_nettype wire
